// File: shared/hoc_pkg.sv
// package: constants and carrier types of the harmonic overcurrent stage
// Functional notes
// - with forcing enabled the forced code 0..3 overrides the stage state.
// - one harmonic order is selectable; second harmonic after reset.
// - mode picks per unit or relative to fundamental; per unit by default.
// - input is three phases, residual one or residual two; phases by default.
// - each instance holds its own settings and runs independently.
// - one common threshold; pick-up when any phase exceeds it.
// - pick-up releases only below 97 % of the active threshold.
// - per unit 0.05..2.00 default 0.20; relative 5..200 % default 20 %.
// - pick-up alone is not start; start only while blocking is inactive.
// - stage condition readable as 0 normal, 1 start, 2 trip, 3 blocked.
// - live measured to threshold ratio in hundredths, capped at 100000.
// - expected operating time up to 1800 s in 5 ms steps, kept current.
// - signed remaining time to trip within 1800 s in 5 ms steps.
// - blocking input sampled at the start of every processing cycle.
// - blocked at pick-up asserts blocked and skips start and delay.
// - blocking after start drops start and runs normal release timing.
// - blocking activation emits a stamped event with start current and fault.
// - harmonic inputs are refreshed on the 5 ms processing time base.
// - start, trip and blocked give on and off events stamped in 1 ms.
package hoc_pkg;
   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_HZ    = 20_000_000;
   localparam int PROC_MS   = 5;
   localparam int PROC_CLKS = CLK_HZ / 1000 * PROC_MS;
   localparam int TS_MS     = 1;
   localparam int TS_CLKS   = CLK_HZ / 1000 * TS_MS;
   localparam int NCH       = 5;
   localparam int NORD      = 12;
   localparam int MW        = 16;
   localparam int DIVW      = 48;

   // ---------------------------------------------------------------
   // register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] A_CTRL   = 8'h00;
   localparam logic [7:0] A_THR_PU = 8'h04;
   localparam logic [7:0] A_THR_RL = 8'h08;
   localparam logic [7:0] A_OPDLY  = 8'h0c;
   localparam logic [7:0] A_RLSDLY = 8'h10;
   localparam logic [7:0] A_STATUS = 8'h14;
   localparam logic [7:0] A_RATIO  = 8'h18;
   localparam logic [7:0] A_EXPT   = 8'h1c;
   localparam logic [7:0] A_REMT   = 8'h20;
   localparam logic [7:0] A_TIME   = 8'h24;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int CTRL_FEN  = 0;
   localparam int CTRL_FST  = 1;
   localparam int CTRL_HSEL = 3;
   localparam int CTRL_REL  = 7;
   localparam int CTRL_INS  = 8;
   localparam int STAT_PICK = 2;
   localparam int STAT_PK   = 3;

   // ---------------------------------------------------------------
   // reset values and limits
   // ---------------------------------------------------------------
   localparam logic [3:0]  HSEL_RST   = 4'h0;
   localparam logic [3:0]  HSEL_MAX   = 4'hb;
   localparam logic [1:0]  INS_PH     = 2'h0;
   localparam logic [1:0]  INS_R1     = 2'h1;
   localparam logic [1:0]  INS_R2     = 2'h2;
   localparam logic [15:0] THR_PU_RST = 16'h0014;
   localparam logic [15:0] THR_PU_MIN = 16'h0005;
   localparam logic [15:0] THR_PU_MAX = 16'h00c8;
   localparam logic [15:0] THR_RL_RST = 16'h07d0;
   localparam logic [15:0] THR_RL_MIN = 16'h01f4;
   localparam logic [15:0] THR_RL_MAX = 16'h4e20;
   localparam logic [18:0] OPT_MAX    = 19'h57e40;
   localparam logic [18:0] OPDLY_RST  = 19'h00014;
   localparam logic [18:0] RLSDLY_RST = 19'h00000;
   localparam logic [23:0] RATIO_MAX  = 24'h989680;
   localparam logic [6:0]  PCT_PICK   = 7'h64;
   localparam logic [6:0]  PCT_DROP   = 7'h61;
   localparam logic [47:0] PU_SCALE   = 48'h64;
   localparam logic [47:0] REL_SCALE  = 48'hf4240;

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {HOC_NORMAL, HOC_START, HOC_TRIP, HOC_BLOCKED} hoc_cond_t;

   typedef struct packed {
      logic [NCH-1:0][MW-1:0]           fund;
      logic [NCH-1:0][NORD-1:0][MW-1:0] harm;
   } hoc_meas_t;

   typedef struct packed {
      logic [31:0]    ts;
      logic [2:0]     on;
      logic [2:0]     off;
      logic [MW-1:0]  cur;
      logic [NCH-1:0] fault;
   } hoc_evt_t;
endpackage

// File: hdl/hoc_div.sv
// module: iterative restoring divider for the ratio readout
`timescale 1ns/1ps
module hoc_div #(
   parameter int NW = 48
) (
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic          start,
   input  wire logic [NW-1:0] num,
   input  wire logic [NW-1:0] den,
   output logic               done,
   output logic [NW-1:0]      quot
);
   localparam int CW = $clog2(NW) + 1;

   typedef struct packed {
      logic          busy;
      logic [CW-1:0] cnt;
      logic [NW:0]   rem;
      logic [NW-1:0] den;
      logic [NW-1:0] quo;
      logic          done;
   } hoc_div_st_t;

   hoc_div_st_t q;
   hoc_div_st_t n;

   // zero divisor yields all ones, which the caller treats as saturation
   always_comb begin
      logic [NW:0] t;
      n = q;
      t = '0;
      n.done = 1'b0;
      if (start && !q.busy) begin
         n.busy = 1'b1;
         n.cnt  = CW'(NW);
         n.rem  = '0;
         n.den  = den;
         n.quo  = num;
      end else if (q.busy) begin
         t = {q.rem[NW-1:0], q.quo[NW-1]};
         n.quo = {q.quo[NW-2:0], 1'b0};
         if (t >= {1'b0, q.den}) begin
            n.rem    = t - {1'b0, q.den};
            n.quo[0] = 1'b1;
         end else begin
            n.rem = t;
         end
         n.cnt = q.cnt - 1'b1;
         if (q.cnt == CW'(1)) begin
            n.busy = 1'b0;
            n.done = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign done = q.done;
   assign quot = q.quo;
endmodule

// File: hdl/hoc_stage.sv
// module: harmonic overcurrent stage with apb settings and readouts
//
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module hoc_stage #(
   parameter int PROC_CLKS = hoc_pkg::PROC_CLKS,
   parameter int TS_CLKS   = hoc_pkg::TS_CLKS
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire hoc_pkg::hoc_meas_t meas,
   input  wire logic              block_in,
   output logic                   start_out,
   output logic                   trip_out,
   output logic                   blocked_out,
   output logic [1:0]             condition,
   output logic                   event_valid,
   output hoc_pkg::hoc_evt_t      event_rec
);
   localparam int PCW = $clog2(PROC_CLKS);
   localparam int MCW = $clog2(TS_CLKS);
   localparam int DW  = hoc_pkg::DIVW;

   typedef struct packed {
      logic                     fen;
      hoc_pkg::hoc_cond_t       fst;
      logic [3:0]               hsel;
      logic                     rel;
      logic [1:0]               ins;
      logic [15:0]              thr_pu;
      logic [15:0]              thr_rl;
      logic [18:0]              op_dly;
      logic [18:0]              rls_dly;
      logic [PCW-1:0]           pcnt;
      logic [MCW-1:0]           mcnt;
      logic [31:0]              ms;
      logic                     tick;
      logic [4:0][15:0]         h;
      logic [4:0][15:0]         f;
      logic [4:0]               pk;
      logic                     blk;
      hoc_pkg::hoc_cond_t       st;
      logic [18:0]              dcnt;
      logic [18:0]              rcnt;
      logic [15:0]              cap;
      logic [23:0]              ratio;
      logic [18:0]              exp_t;
      logic signed [19:0]       rem;
      logic                     dgo;
      logic [2:0]               outs;
      hoc_pkg::hoc_cond_t       cond;
      logic                     ev;
      hoc_pkg::hoc_evt_t        evt;
      logic                     rdy;
      logic                     err;
      logic [31:0]              rd;
   } hoc_state_t;

   hoc_state_t q;
   hoc_state_t n;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [47:0] scaled(input logic [15:0] h, input logic rel);
      return rel ? 48'(h) * hoc_pkg::REL_SCALE : 48'(h) * hoc_pkg::PU_SCALE;
   endfunction

   function automatic logic [47:0] limit(input logic [15:0] f, input logic [15:0] thr,
                                         input logic rel, input logic [6:0] pct);
      return rel ? 48'(f) * 48'(thr) * 48'(pct) : 48'(thr) * 48'(pct);
   endfunction

   function automatic logic [2:0] max_ch(input logic [4:0][15:0] h, input logic [4:0] m);
      logic [2:0] b;
      logic       found;
      b = '0;
      found = 1'b0;
      for (int c = 0; c < 5; c++) begin
         if (m[c] && (!found || h[c] > h[b])) begin
            b = 3'(c);
            found = 1'b1;
         end
      end
      return b;
   endfunction

   function automatic logic [4:0] chan_mask(input logic [1:0] ins);
      unique case (ins)
         hoc_pkg::INS_R1: return 5'h08;
         hoc_pkg::INS_R2: return 5'h10;
         default:         return 5'h07;
      endcase
   endfunction

   function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo,
                                         input logic [15:0] hi);
      return (v < lo) ? lo : (v > hi) ? hi : v;
   endfunction

   // {start, trip, blocked}
   function automatic logic [2:0] outs_of(input hoc_pkg::hoc_cond_t c);
      return {c == hoc_pkg::HOC_START, c == hoc_pkg::HOC_TRIP, c == hoc_pkg::HOC_BLOCKED};
   endfunction

   // ---------------------------------------------------------------
   // comparator
   // ---------------------------------------------------------------
   logic [4:0][15:0] sel_h;
   logic [4:0]       over;
   logic [4:0]       under;
   logic [4:0]       pk_new;
   logic [4:0]       mask;
   logic [15:0]      thr;
   logic             pick;
   logic [2:0]       dch;
   logic             div_done;
   logic [DW-1:0]    div_q;

   assign mask = chan_mask(q.ins);
   assign thr  = q.rel ? q.thr_rl : q.thr_pu;

   for (genvar c = 0; c < 5; c++) begin : g_cmp
      assign sel_h[c] = meas.harm[c][q.hsel];
      assign over[c]  = scaled(sel_h[c], q.rel) > limit(meas.fund[c], thr, q.rel, hoc_pkg::PCT_PICK);
      assign under[c] = scaled(sel_h[c], q.rel) < limit(meas.fund[c], thr, q.rel, hoc_pkg::PCT_DROP);
      assign pk_new[c] = over[c] | (q.pk[c] & ~under[c]);
   end

   // any one, two or three phases
   assign pick = |(pk_new & mask);
   assign dch  = max_ch(q.h, mask);

   // ratio of measured to threshold in hundredths
   hoc_div #(
      .NW (DW)
   ) u_div (
      .pclk    (pclk),
      .presetn (presetn),
      .start   (q.dgo),
      .num     (scaled(q.h[dch], q.rel)),
      .den     (q.rel ? 48'(q.f[dch]) * 48'(thr) : 48'(thr)),
      .done    (div_done),
      .quot    (div_q)
   );

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      n = q;
      n.tick = 1'b0;
      n.dgo  = 1'b0;
      n.ev   = 1'b0;
      n.rdy  = 1'b0;
      n.err  = 1'b0;

      if (q.pcnt == PCW'(PROC_CLKS - 1)) begin
         n.pcnt = '0;
         n.tick = 1'b1;
      end else begin
         n.pcnt = q.pcnt + 1'b1;
      end
      if (q.mcnt == MCW'(TS_CLKS - 1)) begin
         n.mcnt = '0;
         n.ms   = q.ms + 1'b1;
      end else begin
         n.mcnt = q.mcnt + 1'b1;
      end

      // one wait state: answer in the second access cycle
      if (psel && penable && !q.rdy) begin
         n.rdy = 1'b1;
         n.rd  = '0;
         unique case (paddr)
            hoc_pkg::A_CTRL: begin
               // settings are private to this instance
               if (pwrite) begin
                  n.fen = pwdata[hoc_pkg::CTRL_FEN];
                  n.fst = hoc_pkg::hoc_cond_t'(pwdata[hoc_pkg::CTRL_FST +: 2]);
                  if (pwdata[hoc_pkg::CTRL_HSEL +: 4] <= hoc_pkg::HSEL_MAX) begin
                     n.hsel = pwdata[hoc_pkg::CTRL_HSEL +: 4];
                  end
                  n.rel = pwdata[hoc_pkg::CTRL_REL];
                  if (pwdata[hoc_pkg::CTRL_INS +: 2] != 2'h3) begin
                     n.ins = pwdata[hoc_pkg::CTRL_INS +: 2];
                  end
               end
               n.rd[hoc_pkg::CTRL_FEN]       = q.fen;
               n.rd[hoc_pkg::CTRL_FST +: 2]  = q.fst;
               n.rd[hoc_pkg::CTRL_HSEL +: 4] = q.hsel;
               n.rd[hoc_pkg::CTRL_REL]       = q.rel;
               n.rd[hoc_pkg::CTRL_INS +: 2]  = q.ins;
            end
            hoc_pkg::A_THR_PU: begin
               if (pwdata[31:16] != 16'h0) begin
                  if (pwrite) n.thr_pu = hoc_pkg::THR_PU_MAX;
               end else if (pwrite) begin
                  n.thr_pu = clamp(pwdata[15:0], hoc_pkg::THR_PU_MIN, hoc_pkg::THR_PU_MAX);
               end
               n.rd[15:0] = q.thr_pu;
            end
            hoc_pkg::A_THR_RL: begin
               if (pwdata[31:16] != 16'h0) begin
                  if (pwrite) n.thr_rl = hoc_pkg::THR_RL_MAX;
               end else if (pwrite) begin
                  n.thr_rl = clamp(pwdata[15:0], hoc_pkg::THR_RL_MIN, hoc_pkg::THR_RL_MAX);
               end
               n.rd[15:0] = q.thr_rl;
            end
            hoc_pkg::A_OPDLY: begin
               if (pwrite) begin
                  n.op_dly = (pwdata > 32'(hoc_pkg::OPT_MAX)) ? hoc_pkg::OPT_MAX : pwdata[18:0];
               end
               n.rd[18:0] = q.op_dly;
            end
            hoc_pkg::A_RLSDLY: begin
               if (pwrite) begin
                  n.rls_dly = (pwdata > 32'(hoc_pkg::OPT_MAX)) ? hoc_pkg::OPT_MAX : pwdata[18:0];
               end
               n.rd[18:0] = q.rls_dly;
            end
            hoc_pkg::A_STATUS: begin
               n.rd[1:0]                    = q.cond;
               n.rd[hoc_pkg::STAT_PICK]     = |(q.pk & mask);
               n.rd[hoc_pkg::STAT_PK +: 5]  = q.pk;
            end
            hoc_pkg::A_RATIO: n.rd[23:0] = q.ratio;
            hoc_pkg::A_EXPT:  n.rd[18:0] = q.exp_t;
            hoc_pkg::A_REMT:  n.rd       = 32'(q.rem);
            hoc_pkg::A_TIME:  n.rd       = q.ms;
            default:          n.err      = 1'b1;
         endcase
      end

      if (q.tick) begin
         // inputs refreshed once per processing cycle
         n.h  = sel_h;
         n.f  = meas.fund;
         n.pk = pk_new;
         // blocking sampled before pick-up is acted on
         n.blk = block_in;
         n.dgo = 1'b1;
         if (q.rcnt != '0) begin
            n.rcnt = q.rcnt - 1'b1;
         end else if (q.st != hoc_pkg::HOC_START) begin
            n.dcnt = '0;
         end
         unique case (q.st)
            hoc_pkg::HOC_NORMAL: begin
               if (pick) begin
                  n.cap = sel_h[max_ch(sel_h, mask)];
                  // blocked at pick-up skips start and delay
                  n.st = block_in ? hoc_pkg::HOC_BLOCKED : hoc_pkg::HOC_START;
               end
            end
            hoc_pkg::HOC_START: begin
               // blocking after start releases like a pick-up drop
               if (!pick || block_in) begin
                  n.st   = pick ? hoc_pkg::HOC_BLOCKED : hoc_pkg::HOC_NORMAL;
                  n.rcnt = q.rls_dly;
               end else begin
                  n.dcnt = q.dcnt + 1'b1;
                  if (q.dcnt + 1'b1 >= q.op_dly) begin
                     n.st = hoc_pkg::HOC_TRIP;
                  end
               end
            end
            hoc_pkg::HOC_TRIP: begin
               if (!pick) begin
                  n.st   = hoc_pkg::HOC_NORMAL;
                  n.rcnt = q.rls_dly;
               end else if (block_in) begin
                  n.st = hoc_pkg::HOC_BLOCKED;
               end
            end
            hoc_pkg::HOC_BLOCKED: begin
               if (!pick) begin
                  n.st = hoc_pkg::HOC_NORMAL;
               end else if (!block_in) begin
                  n.st = hoc_pkg::HOC_START;
               end
            end
         endcase
         // expected operating time follows the delay setting
         n.exp_t = q.op_dly;
         n.rem = (n.st == hoc_pkg::HOC_START) ? 20'(q.op_dly) - 20'(n.dcnt) : 20'sh0;
      end

      if (div_done) begin
         n.ratio = (div_q > 48'(hoc_pkg::RATIO_MAX)) ? hoc_pkg::RATIO_MAX : div_q[23:0];
      end

      // forced code overrides the stage state
      n.cond = q.fen ? q.fst : q.st;
      n.outs = outs_of(n.cond);
      // on and off stamps for every output
      // blocking event carries start current and fault type
      if (n.outs != q.outs) begin
         n.ev        = 1'b1;
         n.evt.ts    = q.ms;
         n.evt.on    = n.outs & ~q.outs;
         n.evt.off   = q.outs & ~n.outs;
         n.evt.cur   = q.cap;
         n.evt.fault = q.pk & mask;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q        <= '0;
         q.hsel   <= hoc_pkg::HSEL_RST;
         q.ins    <= hoc_pkg::INS_PH;
         q.thr_pu <= hoc_pkg::THR_PU_RST;
         q.thr_rl <= hoc_pkg::THR_RL_RST;
         q.op_dly <= hoc_pkg::OPDLY_RST;
         q.rls_dly <= hoc_pkg::RLSDLY_RST;
      end else begin
         q <= n;
      end
   end

   assign prdata      = q.rd;
   assign pready      = q.rdy;
   assign pslverr     = q.err;
   assign start_out   = q.outs[2];
   assign trip_out    = q.outs[1];
   assign blocked_out = q.outs[0];
   assign condition   = q.cond;
   assign event_valid = q.ev;
   assign event_rec   = q.evt;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   chk_force_cond: assert property (
      @(posedge pclk) disable iff (!presetn) q.fen |=> condition == $past(q.fst))
      else $error("forced code not shown on condition");

   chk_hsel_legal: assert property (
      @(posedge pclk) disable iff (!presetn) q.hsel <= hoc_pkg::HSEL_MAX)
      else $error("harmonic order out of list");

   chk_thr_range: assert property (
      @(posedge pclk) disable iff (!presetn)
      q.thr_pu inside {[hoc_pkg::THR_PU_MIN:hoc_pkg::THR_PU_MAX]} &&
      q.thr_rl inside {[hoc_pkg::THR_RL_MIN:hoc_pkg::THR_RL_MAX]})
      else $error("threshold outside range");

   chk_start_unblk: assert property (
      @(posedge pclk) disable iff (!presetn) q.st == hoc_pkg::HOC_START |-> !q.blk)
      else $error("start held while blocked");

   chk_block_entry: assert property (
      @(posedge pclk) disable iff (!presetn)
      q.tick && pick && block_in && q.st == hoc_pkg::HOC_NORMAL |=>
      q.st == hoc_pkg::HOC_BLOCKED ##1 q.dcnt == '0 || q.rcnt != '0)
      else $error("pick-up under blocking did not block");

   chk_start_rls: assert property (
      @(posedge pclk) disable iff (!presetn)
      q.tick && block_in && q.st == hoc_pkg::HOC_START |=>
      q.st != hoc_pkg::HOC_START && q.rcnt == $past(q.rls_dly))
      else $error("blocking did not release start");

   chk_ratio_cap: assert property (
      @(posedge pclk) disable iff (!presetn) div_done |=> q.ratio <= hoc_pkg::RATIO_MAX)
      else $error("ratio above ceiling");

   chk_meas_latch: assert property (
      @(posedge pclk) disable iff (!presetn) q.tick |=> q.h == $past(sel_h) ##1 !q.tick)
      else $error("inputs not refreshed on tick");

   chk_out_event: assert property (
      @(posedge pclk) disable iff (!presetn)
      $changed(q.outs) |-> event_valid && event_rec.on == (q.outs & ~$past(q.outs)))
      else $error("output change without event");
endmodule

// File: sim/hoc_src.sv
// partner model: measurement preprocessing and blocking matrix
`timescale 1ns/1ps
module hoc_src (
   input  wire logic          pclk,
   input  wire logic [15:0]   lvl,
   input  wire logic [2:0]    ch,
   input  wire logic          blk,
   output hoc_pkg::hoc_meas_t meas,
   output logic               block_in
);
   // -------------------------------------------
   // refresh
   // -------------------------------------------
   // refresh every cycle
   // big 3rd order and residual values expose a wrong order or input pick
   always_ff @(posedge pclk) begin
      meas <= '0;
      for (int c = 0; c < hoc_pkg::NCH; c++) begin
         meas.fund[c]    <= 16'h0064;
         meas.harm[c][1] <= 16'h00c8;
      end
      meas.harm[3][0]  <= 16'h00c8;
      meas.harm[4][0]  <= 16'h00c8;
      meas.harm[ch][0] <= lvl;
      block_in <= blk;
   end
endmodule

// File: sim/testbench.sv
// testbench: apb master, reference pick-up model and verdict
`timescale 1ns/1ps
module testbench;
   // -------------------------------------------
   // signals
   // -------------------------------------------
   localparam int P = 40;
   logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, blk, er;
   logic              start_out, trip_out, blocked_out;
   logic [1:0]        condition;
   logic [2:0]        ch;
   logic [7:0]        paddr, lf;
   logic [15:0]       lvl;
   logic [31:0]       pwdata, prdata, rd;
   hoc_pkg::hoc_meas_t meas;
   logic              block_in;
   int                err_total, checked, pk, m;
   int                pc[3];
   logic              evv;
   hoc_pkg::hoc_evt_t evr, ev;
   int                tab[6] = '{25, 20, 19, 20, 21, 19};

   hoc_src SRC (.pclk(pclk), .lvl(lvl), .ch(ch), .blk(blk), .meas(meas), .block_in(block_in));
   hoc_stage #(.PROC_CLKS(P), .TS_CLKS(8)) DUT (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .meas(meas), .block_in(block_in), .start_out(start_out), .trip_out(trip_out),
      .blocked_out(blocked_out), .condition(condition), .event_valid(evv), .event_rec(evr));

   always #25 pclk = ~pclk;

   // last event record, for the event field checks
   always @(posedge pclk) if (evv === 1'b1) ev <= evr;

   // -------------------------------------------
   // tasks
   // -------------------------------------------
   function automatic logic [7:0] lfsr(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic ticks(input int n);
      repeat (n * P) @(posedge pclk);
   endtask

   task automatic print_verdict;
      if (err_total == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // -------------------------------------------
   // sequence
   // -------------------------------------------
   initial begin
      pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
      lvl = 0; ch = 0; blk = 0; err_total = 0; checked = 0; pk = 0; lf = 8'h60;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, hoc_pkg::A_CTRL, 0); chk(rd, 0);
      apb(0, hoc_pkg::A_THR_PU, 0); chk(rd, 32'h14);
      apb(0, hoc_pkg::A_THR_RL, 0); chk(rd, 32'h7d0);
      apb(0, 8'h3c, 0); chk({rd[30:0], er}, 1);
      apb(1, hoc_pkg::A_OPDLY, 32'h3e8);
      // fixed edges of the hysteresis band first, then random levels and phases
      for (int i = 0; i < 20; i++) begin
         lf = lfsr(lf);
         m = (i < 6) ? tab[i] : 8 + lf % 24;
         lvl <= m[15:0];
         ch <= (i < 6) ? 3'h0 : 3'(lf % 3);
         ticks(3);
         // hysteresis is held per phase, so a level moved to another phase starts afresh
         foreach (pc[c]) pc[c] = (c != ch) ? 0 : (m * 100 > 2000) ? 1 : ((m * 100 < 1940) ? 0 : pc[c]);
         pk = pc[0] | pc[1] | pc[2];
         chk(start_out, pk);
         chk(condition, pk);
      end
      lvl <= 16'h0019; ticks(3);
      blk <= 1'b1; ticks(3);
      chk({start_out, trip_out, blocked_out, condition}, 5'h07);
      blk <= 1'b0; lvl <= 0; ticks(3);
      apb(1, hoc_pkg::A_OPDLY, 2);
      lvl <= 16'h0019; ticks(7);
      chk({trip_out, condition}, 3'h6);
      for (int i = 0; i < 4; i++) begin
         apb(1, hoc_pkg::A_CTRL, 1 | (i << 1)); ticks(2);
         chk({start_out, trip_out, blocked_out, condition}, {3'(i == 0 ? 0 : 4 >> (i - 1)), 2'(i)});
      end
      lvl <= 0;
      apb(1, hoc_pkg::A_CTRL, 6); ticks(3);
      chk(condition, 0);
      // pick-up under blocking, then input, mode and order selection
      apb(1, hoc_pkg::A_OPDLY, 32'h3e8);
      blk <= 1'b1; ticks(2);
      lvl <= 16'h0019; ticks(3);
      chk({start_out, trip_out, blocked_out, condition}, 5'h07);
      chk({ev.on, ev.off, ev.cur, ev.fault}, {6'h08, 16'h0019, 5'(1 << ch)});
      blk <= 1'b0; ch <= 3'h3;
      apb(1, hoc_pkg::A_THR_RL, 32'hbb8);
      apb(1, hoc_pkg::A_CTRL, 32'h180); ticks(3);
      chk(condition, 0);
      lvl <= 16'h0028; ticks(3);
      chk(condition, 1);
      apb(1, hoc_pkg::A_CTRL, 32'h3e0);
      apb(0, hoc_pkg::A_CTRL, 0); chk(rd, 32'h180);
      apb(1, hoc_pkg::A_CTRL, 32'h188); lvl <= 0; ticks(5);
      chk(condition, 1);
      apb(0, hoc_pkg::A_RATIO, 0); chk(rd, 32'h29a);
      apb(0, hoc_pkg::A_EXPT, 0); chk(rd, 32'h3e8);
      print_verdict;
   end

   initial begin
      #(50 * 20000);
      err_total++;
      print_verdict;
   end
endmodule
